/* File: prt_pkg.sv */
// types shared by the tachometer
`default_nettype none

package prt_pkg;

  typedef enum logic [1:0] {
    prt_upper_lower_band_mode = 2'b00,
    prt_zone_mode             = 2'b01,
    prt_dual_upper_mode       = 2'b10,
    prt_dual_lower_mode       = 2'b11
  } prt_mode_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic        filt;
    logic [23:0] deb_cnt;
    logic [23:0] tick_cnt;
    logic [3:0]  samp_steps;
    logic [15:0] edge_cnt;
    logic [18:0] acc;
    logic [3:0]  n_samp;
    logic [13:0] idle_steps;
    logic [13:0] up_steps;
    logic [23:0] meas;
    logic        first_limit_output;
    logic        second_limit_output;
    logic        zero_seen;
    prt_mode_t   mode;
    logic        fast;
    logic [1:0]  avg;
    logic        sourcing;
    logic [1:0]  dp;
    logic [15:0] scale;
    logic [23:0] lim1;
    logic [23:0] lim2;
    logic [13:0] ztime;
    logic [13:0] stime;
    logic [3:0]  sts;
    logic [3:0]  msk;
    logic [31:0] prdata;
  } prt_state_t;

endpackage

`default_nettype wire

/* File: prt_pulse_src.sv */
// sensor model: pulse train on the count pin with optional contact bounce
`timescale 1ns/1ps
`default_nettype none

module prt_pulse_src (
  input  wire logic       clk_i,    // bench clock
  input  wire logic       en_i,     // train running
  input  wire logic [7:0] period_i, // cycles per pulse
  input  wire logic [7:0] width_i,  // cycles at high level
  input  wire logic       bounce_i, // bounce after each rise
  output logic            pin_o     // sensor pin
);
  logic [7:0] cnt_q = 8'h00;
  logic       pin_q = 1'b0;

  assign pin_o = pin_q;

  // an idle sensor rests low; a bounce opens the contact for two cycles after a two-cycle first touch
  always @(posedge clk_i)
  begin
    if (!en_i)
    begin
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q + 8'h01 >= period_i) ? 8'h00 : cnt_q + 8'h01;
      pin_q <= (cnt_q < width_i) && !(bounce_i && (cnt_q == 8'h02 || cnt_q == 8'h03));
    end
  end
endmodule

`default_nettype wire

/* File: prt_regs.svh */
// register offsets, field positions, reset values and timing counts of the tachometer
`ifndef PRT_REGS_SVH
`define PRT_REGS_SVH

// register byte offsets
`define PRT_CTRL_OFS      8'h00
`define PRT_SCALE_OFS     8'h04
`define PRT_LIMIT1_OFS    8'h08
`define PRT_LIMIT2_OFS    8'h0C
`define PRT_ZTIME_OFS     8'h10
`define PRT_STIME_OFS     8'h14
`define PRT_MEAS_OFS      8'h18
`define PRT_STATUS_OFS    8'h1C
`define PRT_MASK_OFS      8'h20

// control register fields
`define PRT_CTRL_MODE_POS 0
`define PRT_CTRL_FAST_POS 2
`define PRT_CTRL_AVG_POS  3
`define PRT_CTRL_SRC_POS  5
`define PRT_CTRL_DP_POS   6

// status / mask bit positions
`define PRT_ST_UPDATE     0
`define PRT_ST_FIRST_LIMIT_OUTPUT       1
`define PRT_ST_SECOND_LIMIT_OUTPUT       2
`define PRT_ST_ZERO       3

// reset values
`define PRT_CTRL_RST      9'h000
`define PRT_SCALE_RST     16'h0100
`define PRT_LIMIT_RST     24'h00_0000
`define PRT_ZTIME_RST     14'h0064
`define PRT_STIME_RST     14'h0000
`define PRT_MASK_RST      4'h0

// timing
`define PRT_CLK_PERIOD_NS 5
`define PRT_STEP_NS       10000000
`define PRT_CHATTER_NS    5000000
`define PRT_SAMPLE_STEPS  4'd10
`define PRT_SAMPLES_PER_S 20'd10
`define PRT_TIME_MAX      14'h3FFF

`endif

/* File: prt_tacho.sv */
// pulse rate tachometer with apb registers, averaging and two limit outputs
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "prt_regs.svh"
`default_nettype none

module prt_tacho
  import prt_pkg::*;
#(
  parameter int unsigned STEP_CYCLES    = (`PRT_STEP_NS + `PRT_CLK_PERIOD_NS - 1) / `PRT_CLK_PERIOD_NS,
  parameter int unsigned CHATTER_CYCLES = (`PRT_CHATTER_NS + `PRT_CLK_PERIOD_NS - 1) / `PRT_CLK_PERIOD_NS
)
(
  input  wire logic        clk_i,                    // 200 MHz clock
  input  wire logic        rst_b_i,                  // async reset, active low
  input  wire logic        psel_i,                   // apb select
  input  wire logic        penable_i,                // apb enable
  input  wire logic        pwrite_i,                 // apb write
  input  wire logic [7:0]  paddr_i,                  // apb byte address
  input  wire logic [31:0] pwdata_i,                 // apb write data
  output logic      [31:0] prdata_o,                 // apb read data
  output logic             pready_o,                 // apb ready
  output logic             pslverr_o,                // apb error
  input  wire logic        pulse_input_i,            // sensor pin
  output logic             first_limit_output_o,     // limit output 1
  output logic             second_limit_output_o,    // limit output 2
  output logic      [23:0] measurement_o,            // scaled value
  output logic      [1:0]  decimal_place_position_o, // display point
  output logic             irq_o                     // level interrupt
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prt_state_t  q;
  prt_state_t  d;
  logic        active;
  logic        rise;
  logic        tick;
  logic        samp_end;
  logic        inhibit;
  logic        zero_now;
  logic        pub;
  logic        cmp1;
  logic        cmp2;
  logic        wr;
  logic        rd_setup;
  logic        hit;
  logic [3:0]  n_need;
  logic [18:0] sum;
  logic [15:0] avg_cnt;
  logic [19:0] freq;
  logic [35:0] prod;
  logic [31:0] rdata;
  logic [3:0]  set_ev;
  logic [3:0]  clr_ev;

  always_comb
  begin
    d        = q;
    active   = 1'b0;
    rise     = 1'b0;
    pub      = 1'b0;
    cmp1     = 1'b0;
    cmp2     = 1'b0;
    hit      = 1'b1;
    rdata    = 32'h0000_0000;
    set_ev   = 4'h0;
    clr_ev   = 4'h0;
    wr       = psel_i && penable_i && pwrite_i;
    rd_setup = psel_i && !penable_i && !pwrite_i;
    tick     = q.tick_cnt == 24'(STEP_CYCLES - 1);
    samp_end = tick && (q.samp_steps == `PRT_SAMPLE_STEPS - 4'd1);
    inhibit  = q.up_steps < q.stime;
    zero_now = q.idle_steps >= q.ztime;
    n_need   = 4'b0001 << q.avg;
    sum      = q.acc + 19'(q.edge_cnt);
    avg_cnt  = 16'(sum >> q.avg);
    freq     = 20'(avg_cnt) * `PRT_SAMPLES_PER_S;
    prod     = 36'(freq) * 36'(q.scale);

    // ----------------------------------------------------------------
    // pin input: three stages, polarity, chatter filter
    // ----------------------------------------------------------------
    d.sync = {q.sync[1:0], pulse_input_i};
    if (q.sync[1] == q.sync[2])
      active = q.sourcing ? q.sync[2] : ~q.sync[2];
    else
      active = q.filt;
    if (q.fast)
    begin
      d.filt    = active;
      d.deb_cnt = 24'h00_0000;
    end
    else if (active != q.filt)
    begin
      if (q.deb_cnt >= 24'(CHATTER_CYCLES - 1))
      begin
        d.filt    = active;
        d.deb_cnt = 24'h00_0000;
      end
      else
        d.deb_cnt = q.deb_cnt + 24'h00_0001;
    end
    else
      d.deb_cnt = 24'h00_0000;
    rise = d.filt && !q.filt;

    // ----------------------------------------------------------------
    // time base in 0.01 s steps
    // ----------------------------------------------------------------
    d.tick_cnt = tick ? 24'h00_0000 : q.tick_cnt + 24'h00_0001;
    if (tick && q.up_steps != `PRT_TIME_MAX)
      d.up_steps = q.up_steps + 14'h0001;
    if (rise)
      d.idle_steps = 14'h0000;
    else if (tick && q.idle_steps != `PRT_TIME_MAX)
      d.idle_steps = q.idle_steps + 14'h0001;

    // ----------------------------------------------------------------
    // sampling and averaging
    // ----------------------------------------------------------------
    if (tick)
      d.samp_steps = samp_end ? 4'h0 : q.samp_steps + 4'h1;
    if (samp_end)
    begin
      d.edge_cnt = {15'h0000, rise};
      if (q.n_samp + 4'h1 >= n_need)
      begin
        pub      = 1'b1;
        d.acc    = 19'h0_0000;
        d.n_samp = 4'h0;
        // mean of the window, scaled by 1/256 units
        if (|prod[35:32])
          d.meas = 24'hFF_FFFF;
        else
          d.meas = prod[31:8];
      end
      else
      begin
        d.acc    = sum;
        d.n_samp = q.n_samp + 4'h1;
      end
    end
    else if (rise && q.edge_cnt != 16'hFFFF)
      d.edge_cnt = q.edge_cnt + 16'h0001;

    if (zero_now)
    begin
      d.meas   = 24'h00_0000;
      d.acc    = 19'h0_0000;
      d.n_samp = 4'h0;
      pub      = 1'b0;
    end
    if (inhibit)
    begin
      d.meas       = 24'h00_0000;
      d.acc        = 19'h0_0000;
      d.n_samp     = 4'h0;
      d.edge_cnt   = 16'h0000;
      d.samp_steps = 4'h0;
      pub          = 1'b0;
    end
    d.zero_seen = zero_now;

    // ----------------------------------------------------------------
    // limit comparison
    // ----------------------------------------------------------------
    unique case (q.mode)
      prt_upper_lower_band_mode:
      begin
        cmp1 = q.meas < q.lim1;
        cmp2 = q.meas > q.lim2;
      end
      prt_zone_mode:
      begin
        cmp1 = (q.meas >= q.lim1) && (q.meas <= q.lim2);
        cmp2 = !cmp1;
      end
      prt_dual_upper_mode:
      begin
        cmp1 = q.meas >= q.lim1;
        cmp2 = q.meas >= q.lim2;
      end
      prt_dual_lower_mode:
      begin
        cmp1 = q.meas <= q.lim1;
        cmp2 = q.meas <= q.lim2;
      end
    endcase
    d.first_limit_output = cmp1 && !inhibit;
    d.second_limit_output = cmp2 && !inhibit;

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    unique case (paddr_i)
      `PRT_CTRL_OFS:   rdata = {24'h00_0000, q.dp, q.sourcing, q.avg, q.fast, q.mode};
      `PRT_SCALE_OFS:  rdata = {16'h0000, q.scale};
      `PRT_LIMIT1_OFS: rdata = {8'h00, q.lim1};
      `PRT_LIMIT2_OFS: rdata = {8'h00, q.lim2};
      `PRT_ZTIME_OFS:  rdata = {18'h0_0000, q.ztime};
      `PRT_STIME_OFS:  rdata = {18'h0_0000, q.stime};
      `PRT_MEAS_OFS:   rdata = {8'h00, q.meas};
      `PRT_STATUS_OFS: rdata = {28'h000_0000, q.sts};
      `PRT_MASK_OFS:   rdata = {28'h000_0000, q.msk};
      default:         hit   = 1'b0;
    endcase
    if (rd_setup)
      d.prdata = rdata;
    if (wr && hit)
    begin
      unique case (paddr_i)
        `PRT_CTRL_OFS:
        begin
          d.mode     = prt_mode_t'(pwdata_i[`PRT_CTRL_MODE_POS +: 2]);
          d.fast     = pwdata_i[`PRT_CTRL_FAST_POS];
          d.avg      = pwdata_i[`PRT_CTRL_AVG_POS +: 2];
          d.sourcing = pwdata_i[`PRT_CTRL_SRC_POS];
          d.dp       = pwdata_i[`PRT_CTRL_DP_POS +: 2];
        end
        `PRT_SCALE_OFS:  d.scale = pwdata_i[15:0];
        `PRT_LIMIT1_OFS: d.lim1  = pwdata_i[23:0];
        `PRT_LIMIT2_OFS: d.lim2  = pwdata_i[23:0];
        `PRT_ZTIME_OFS:  d.ztime = pwdata_i[13:0];
        `PRT_STIME_OFS:  d.stime = pwdata_i[13:0];
        `PRT_STATUS_OFS: clr_ev  = pwdata_i[3:0];
        `PRT_MASK_OFS:   d.msk   = pwdata_i[3:0];
        default:         d.msk   = q.msk;
      endcase
    end

    // events: a set in the clearing cycle wins
    set_ev[`PRT_ST_UPDATE] = pub;
    set_ev[`PRT_ST_FIRST_LIMIT_OUTPUT]   = d.first_limit_output != q.first_limit_output;
    set_ev[`PRT_ST_SECOND_LIMIT_OUTPUT]   = d.second_limit_output != q.second_limit_output;
    set_ev[`PRT_ST_ZERO]   = zero_now && !q.zero_seen;
    d.sts = (q.sts & ~clr_ev) | set_ev;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q          <= '0;
      q.mode     <= prt_upper_lower_band_mode;
      q.scale    <= `PRT_SCALE_RST;
      q.lim1     <= `PRT_LIMIT_RST;
      q.lim2     <= `PRT_LIMIT_RST;
      q.ztime    <= `PRT_ZTIME_RST;
      q.stime    <= `PRT_STIME_RST;
      q.msk      <= `PRT_MASK_RST;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o                 = q.prdata;
  assign pready_o                 = 1'b1;
  assign pslverr_o                = psel_i && penable_i && !hit;
  assign first_limit_output_o     = q.first_limit_output;
  assign second_limit_output_o    = q.second_limit_output;
  assign measurement_o            = q.meas;
  assign decimal_place_position_o = q.dp;
  assign irq_o                    = |(q.sts & q.msk);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  a_inhibit_outs: assert property (inhibit |=> !first_limit_output_o && !second_limit_output_o)
    else $error("limit output active during startup time");

  a_zero_forced: assert property (zero_now |=> measurement_o == 24'h00_0000)
    else $error("measurement not forced to zero after timeout");

  a_idle_restart: assert property (rise |=> q.idle_steps == 14'h0000)
    else $error("zero timer not restarted by edge");

  a_update_time: assert property ($changed(measurement_o) |-> $past(samp_end) || $past(zero_now))
    else $error("measurement changed outside a sample boundary");

  a_band_lower: assert property (!inhibit && q.mode == prt_upper_lower_band_mode && q.meas < q.lim1
                                 |=> first_limit_output_o)
    else $error("band mode lower flag missing");

  a_band_upper: assert property (!inhibit && q.mode == prt_upper_lower_band_mode && q.meas <= q.lim2
                                 |=> !second_limit_output_o)
    else $error("band mode upper flag without cause");

  a_dual_upper: assert property (!inhibit && q.mode == prt_dual_upper_mode && q.meas >= q.lim2
                                 |=> second_limit_output_o)
    else $error("dual upper flag missing");

  a_fast_follow: assert property (q.fast && q.sync[1] == q.sync[2] ##1 q.fast |-> q.filt == $past(active))
    else $error("high speed input not followed at once");

  a_slow_hold: assert property (!q.fast && q.deb_cnt == 24'h00_0000 && active != q.filt
                                |=> q.filt == $past(q.filt))
    else $error("low speed input changed without chatter hold");

  a_raw_hertz: assert property (pub && !zero_now && !inhibit && q.scale == `PRT_SCALE_RST && q.avg == 2'b00
                                |=> measurement_o == 24'($past(freq)))
    else $error("unit scale does not give raw hertz");

  a_point_write: assert property (wr && paddr_i == `PRT_CTRL_OFS
                                  |=> decimal_place_position_o == $past(pwdata_i[`PRT_CTRL_DP_POS +: 2]))
    else $error("decimal place not taken from control write");

  c_publish:   cover property (pub ##[1:1000] pub);
  c_zero:      cover property (zero_now && !q.zero_seen);
  c_both_outs: cover property (first_limit_output_o && second_limit_output_o);
  c_irq:       cover property ($rose(irq_o));

endmodule

`default_nettype wire

/* File: tb_pulse_rate_tachometer.sv */
// self-checking testbench of the pulse rate tachometer
`timescale 1ns/1ps
`include "prt_regs.svh"
`default_nettype none

module tb_pulse_rate_tachometer;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        en = 1'b0;
  logic        bnc = 1'b0;
  logic [7:0]  per = 8'h14;
  logic [7:0]  wid = 8'h0A;
  logic        pin;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        first_limit_output;
  logic        second_limit_output;
  logic [23:0] meas;
  logic [1:0]  dp;
  logic        irq;
  logic [31:0] r;
  logic        e;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;

  prt_tacho #(.STEP_CYCLES(20), .CHATTER_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .pulse_input_i(pin), .first_limit_output_o(first_limit_output), .second_limit_output_o(second_limit_output),
    .measurement_o(meas), .decimal_place_position_o(dp), .irq_o(irq));

  prt_pulse_src src (.clk_i(clk_i), .en_i(en), .period_i(per), .width_i(wid), .bounce_i(bnc), .pin_o(pin));

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) cyc <= cyc + 1;

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // n times: clear the update flag, then wait for the next measurement update
  task automatic wupd(input int n);
    int k;
    repeat (n)
    begin
      wr(`PRT_STATUS_OFS, 32'h0000_0001);
      k = 0;
      do
      begin
        @(posedge clk_i);
        k++;
      end
      while (irq !== 1'b1 && k < 5000);
      if (k >= 5000) n_fail++;
    end
  endtask

  function automatic logic [31:0] exp_meas(input int edges, input logic [15:0] s);
    logic [39:0] v;
    v = (40'(edges) * 40'd10 * 40'(s)) >> 8;
    return (v > 40'hFF_FFFF) ? 32'h00FF_FFFF : 32'(v[23:0]);
  endfunction

  function automatic logic [1:0] exp_out(input int m, input logic [23:0] v, input logic [23:0] a,
                                         input logic [23:0] b);
    case (m)
      0: return {v < a, v > b};
      1: return {(v >= a && v <= b), !(v >= a && v <= b)};
      2: return {v >= a, v >= b};
      default: return {v <= a, v <= b};
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_fail++;
    tally_and_finish;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int          a;
    logic [31:0] sc;
    logic [31:0] l1;
    logic [31:0] l2;
    logic [31:0] dpv;
    logic [7:0]  ofs [6];
    logic [31:0] rv [6];
    int          t;
    ofs = '{`PRT_CTRL_OFS, `PRT_SCALE_OFS, `PRT_LIMIT1_OFS, `PRT_ZTIME_OFS, `PRT_STIME_OFS, `PRT_MASK_OFS};
    rv = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_0000};
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    void'($urandom(32'hb692_66da));
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      chk("reset value", r, rv[i]);
    end
    rd(8'h24);
    chk("unmapped read", r, 32'h0000_0000);
    chk("unmapped error", 32'(e), 32'h0000_0001);
    chk("ready", 32'(pready), 32'h0000_0001);
    $display("test registers done");
    en <= 1'b1;
    wr(`PRT_STIME_OFS, 32'h0000_0032);
    wr(`PRT_LIMIT1_OFS, 32'h00FF_FFFF);
    wr(`PRT_LIMIT2_OFS, 32'h00FF_FFFF);
    wr(`PRT_MASK_OFS, 32'h0000_0001);
    wr(`PRT_CTRL_OFS, 32'h0000_0007);
    repeat (300) @(posedge clk_i);
    chk("inhibited value", 32'(meas), 32'h0000_0000);
    chk("inhibited outputs", 32'({first_limit_output, second_limit_output}), 32'h0000_0000);
    repeat (800) @(posedge clk_i);
    wupd(2);
    repeat (2) @(posedge clk_i);
    chk("raw hertz", 32'(meas), exp_meas(10, 16'h0100));
    chk("outputs after inhibit", 32'({first_limit_output, second_limit_output}), 32'h0000_0003);
    $display("test startup done");
    for (a = 0; a < 4; a++)
    begin
      sc = (a == 0) ? 32'h0000_0100 : $urandom_range(32'h0000_FFFF, 32'h0000_0001);
      dpv = $urandom_range(3, 0);
      wr(`PRT_SCALE_OFS, sc);
      wr(`PRT_CTRL_OFS, 32'h0000_0007 | (a << 3) | (dpv << 6));
      wupd(2);
      chk("scaled value", 32'(meas), exp_meas(10, sc[15:0]));
      chk("decimal place", 32'(dp), dpv);
      t = cyc;
      wupd(1);
      chk("update period", 32'(cyc - t), 32'(200 << a));
    end
    $display("test averaging done");
    wr(`PRT_SCALE_OFS, 32'h0000_0100);
    for (int i = 0; i < 16; i++)
    begin
      l1 = $urandom_range(104, 96);
      l2 = $urandom_range(104, 96);
      wr(`PRT_LIMIT1_OFS, l1);
      wr(`PRT_LIMIT2_OFS, l2);
      wr(`PRT_CTRL_OFS, 32'(4 + i % 4));
      wupd(2);
      repeat (2) @(posedge clk_i);
      chk("limit outputs", 32'({first_limit_output, second_limit_output}), 32'(exp_out(i % 4, 24'h00_0064, l1[23:0], l2[23:0])));
    end
    $display("test limit modes done");
    for (int i = 0; i < 4; i++)
    begin
      wid <= (i < 2) ? 8'h0A : 8'h02;
      bnc <= (i < 2);
      wr(`PRT_CTRL_OFS, (i == 0) ? 32'h0000_0024 : (i == 3) ? 32'h0000_0004 : 32'h0000_0020);
      wupd(2);
      chk("filtered value", 32'(meas), exp_meas((i == 0) ? 20 : (i == 2) ? 0 : 10, 16'h0100));
    end
    $display("test input filter done");
    wr(`PRT_ZTIME_OFS, 32'h0000_0003);
    per <= 8'h28;
    wid <= 8'h14;
    bnc <= 1'b0;
    wr(`PRT_CTRL_OFS, 32'h0000_0024);
    wupd(2);
    chk("value under timeout", 32'(meas), exp_meas(5, 16'h0100));
    en <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk("value after timeout", 32'(meas), 32'h0000_0000);
    rd(`PRT_STATUS_OFS);
    chk("zero status", 32'(r[3]), 32'h0000_0001);
    wr(`PRT_MASK_OFS, 32'h0000_0000);
    @(posedge clk_i);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(`PRT_MASK_OFS, 32'h0000_0008);
    @(posedge clk_i);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    wr(`PRT_STATUS_OFS, 32'h0000_0008);
    @(posedge clk_i);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    $display("test zero and interrupt done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
